// File: verilog/hsq_homing.sv
// Homing sequencer for methods 12, 13, 14 and 17
//
// Contract
// - Codes 15 and 16 are reserved; no search starts for them.
// - 12, home off: fast reverse rise, stop, slow forward fall, slow reverse rise, index.
// - 12, home on: slow forward fall, slow reverse rise, index in reverse.
// - 12, reverse limit: fast forward fall, stop, slow reverse rise, index reverse.
// - 13, home off: fast reverse fall, stop, slow forward rise, index forward.
// - 13, home on: same sequence as with home off.
// - 13, reverse limit: fast forward rise, stop, slow reverse fall, forward rise, index.
// - 14, home off: fast reverse fall, stop, forward rise, reverse fall, index reverse.
// - 14, home on: same sequence as with home off.
// - 14, reverse limit: fast forward rise, stop, slow reverse fall, index reverse.
// - 17, limit off: fast reverse to limit rise, stop, slow forward to fall, stop.
// - 17, limit on: slow forward to limit fall, then stop.
module hsq_homing
    import hsq_pkg::*;
#(
    parameter int DECEL_CYCLES = hsq_pkg::HSQ_DECEL_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic start,
    input wire logic [7:0] method,
    input wire logic home_sw,
    input wire logic rev_limit,
    input wire logic index_pulse,
    output logic [1:0] speed_cmd,
    output logic dir_rev,
    output logic busy,
    output logic done,
    output logic fault
);
    import hsq_pkg::*;

    typedef enum logic [1:0] {
        HSQ_IDLE,
        HSQ_RUN,
        HSQ_DONE,
        HSQ_FAULT
    } hsq_state_e;

    hsq_state_e state;
    hsq_state_e next_state;
    logic [7:0] method_q;
    logic [7:0] next_method_q;
    logic [1:0] variant;
    logic [1:0] next_variant;
    logic [2:0] step;
    logic [2:0] next_step;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [1:0] next_speed_cmd;
    logic next_dir_rev;
    logic next_busy;
    logic next_done;
    logic next_fault;

    logic [HSQ_IN_W-1:0] in_level;
    logic [HSQ_IN_W-1:0] in_rise;
    logic [HSQ_IN_W-1:0] in_fall;
    hsq_step_s cur;
    hsq_step_s nxt;
    logic hit;
    logic lim_turn;
    logic supported;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    hsq_sync #(
        .WIDTH(HSQ_IN_W)
    ) u_sync (
        .clock(clock),
        .rstn(rstn),
        .pin({index_pulse, rev_limit, home_sw}),
        .level(in_level),
        .rise(in_rise),
        .fall(in_fall)
    );

    // ------------------------------------------------------------
    // Current step and its event
    // ------------------------------------------------------------
    always_comb begin
        cur = hsq_step(method_q, variant, step);
        unique case (cur.ev)
            HSQ_EV_HOME_RISE: hit = in_rise[HSQ_IN_HOME];
            HSQ_EV_HOME_FALL: hit = in_fall[HSQ_IN_HOME];
            HSQ_EV_RLIM_RISE: hit = in_rise[HSQ_IN_RLIM];
            HSQ_EV_RLIM_FALL: hit = in_fall[HSQ_IN_RLIM];
            HSQ_EV_INDEX: hit = in_rise[HSQ_IN_INDEX];
            HSQ_EV_DECEL: hit = (cnt >= 32'(DECEL_CYCLES - 1));
            default: hit = 1'b0;
        endcase
        lim_turn = (method_q != HSQ_METHOD_17) && (variant == HSQ_VAR_OFF)
                   && (step == HSQ_STEP_RST) && in_level[HSQ_IN_RLIM];
        supported = (method == HSQ_METHOD_12) || (method == HSQ_METHOD_13)
                    || (method == HSQ_METHOD_14) || (method == HSQ_METHOD_17);
    end

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_method_q = method_q;
        next_variant = variant;
        next_step = step;
        next_cnt = cnt;
        unique case (state)
            HSQ_IDLE, HSQ_DONE, HSQ_FAULT: begin
                if (start) begin
                    next_method_q = method;
                    next_step = HSQ_STEP_RST;
                    next_cnt = HSQ_CNT_RST;
                    if (!supported) begin
                        next_state = HSQ_FAULT;
                    end else begin
                        next_state = HSQ_RUN;
                        if (method == HSQ_METHOD_17) begin
                            next_variant = in_level[HSQ_IN_RLIM] ? HSQ_VAR_ON : HSQ_VAR_OFF;
                        end else begin
                            next_variant = in_level[HSQ_IN_HOME] ? HSQ_VAR_ON : HSQ_VAR_OFF;
                        end
                    end
                end
            end
            HSQ_RUN: begin
                if (lim_turn) begin
                    next_variant = HSQ_VAR_LIMIT;
                    next_step = HSQ_STEP_RST;
                    next_cnt = HSQ_CNT_RST;
                end else if (hit) begin
                    next_cnt = HSQ_CNT_RST;
                    if (cur.last) begin
                        next_state = HSQ_DONE;
                    end else begin
                        next_step = step + 3'h1;
                    end
                end else begin
                    next_cnt = cnt + 32'h0000_0001;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_comb begin
        nxt = hsq_step(next_method_q, next_variant, next_step);
        next_busy = (next_state == HSQ_RUN);
        next_done = (next_state == HSQ_DONE);
        next_fault = (next_state == HSQ_FAULT);
        next_speed_cmd = next_busy ? nxt.speed : HSQ_SPD_ZERO;
        next_dir_rev = next_busy ? nxt.rev : dir_rev;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= HSQ_IDLE;
            method_q <= 8'h00;
            variant <= HSQ_VAR_OFF;
            step <= HSQ_STEP_RST;
            cnt <= HSQ_CNT_RST;
            speed_cmd <= HSQ_SPD_ZERO;
            dir_rev <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            fault <= 1'b0;
        end else begin
            state <= next_state;
            method_q <= next_method_q;
            variant <= next_variant;
            step <= next_step;
            cnt <= next_cnt;
            speed_cmd <= next_speed_cmd;
            dir_rev <= next_dir_rev;
            busy <= next_busy;
            done <= next_done;
            fault <= next_fault;
        end
    end

endmodule : hsq_homing

// File: verilog/hsq_pkg.sv
// Constants, types and step tables of the homing sequencer
package hsq_pkg;

    // ------------------------------------------------------------
    // Method codes
    // ------------------------------------------------------------
    localparam logic [7:0] HSQ_METHOD_12 = 8'h0C;
    localparam logic [7:0] HSQ_METHOD_13 = 8'h0D;
    localparam logic [7:0] HSQ_METHOD_14 = 8'h0E;
    localparam logic [7:0] HSQ_METHOD_15 = 8'h0F;
    localparam logic [7:0] HSQ_METHOD_16 = 8'h10;
    localparam logic [7:0] HSQ_METHOD_17 = 8'h11;

    // ------------------------------------------------------------
    // Speed command codes
    // ------------------------------------------------------------
    localparam logic [1:0] HSQ_SPD_ZERO = 2'h0;
    localparam logic [1:0] HSQ_SPD_LOW = 2'h1;
    localparam logic [1:0] HSQ_SPD_HIGH = 2'h2;

    // ------------------------------------------------------------
    // Sequence variants
    // ------------------------------------------------------------
    localparam logic [1:0] HSQ_VAR_OFF = 2'h0;
    localparam logic [1:0] HSQ_VAR_ON = 2'h1;
    localparam logic [1:0] HSQ_VAR_LIMIT = 2'h2;

    // ------------------------------------------------------------
    // Synchroniser bit positions
    // ------------------------------------------------------------
    localparam int HSQ_IN_HOME = 0;
    localparam int HSQ_IN_RLIM = 1;
    localparam int HSQ_IN_INDEX = 2;
    localparam int HSQ_IN_W = 3;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [2:0] HSQ_STEP_RST = 3'h0;
    localparam logic [31:0] HSQ_CNT_RST = 32'h0000_0000;
    localparam int HSQ_CLK_PERIOD_NS = 8;
    localparam int HSQ_DECEL_TIME_NS = 1000000;
    localparam int HSQ_DECEL_CYCLES = HSQ_DECEL_TIME_NS / HSQ_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Step description
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HSQ_EV_HOME_RISE,
        HSQ_EV_HOME_FALL,
        HSQ_EV_RLIM_RISE,
        HSQ_EV_RLIM_FALL,
        HSQ_EV_INDEX,
        HSQ_EV_DECEL
    } hsq_event_e;

    typedef struct packed {
        logic [1:0] speed;
        logic rev;
        hsq_event_e ev;
        logic last;
    } hsq_step_s;

    function automatic hsq_step_s hsq_mk(input logic [1:0] sp, input logic rv,
                                         input hsq_event_e ev, input logic lst);
        hsq_step_s r;
        r.speed = sp;
        r.rev = rv;
        r.ev = ev;
        r.last = lst;
        return r;
    endfunction : hsq_mk

    // Step table per method, variant and step number
    function automatic hsq_step_s hsq_step(input logic [7:0] m, input logic [1:0] v,
                                           input logic [2:0] s);
        hsq_step_s r;
        hsq_step_s dc;
        logic zrev;
        dc = hsq_mk(HSQ_SPD_ZERO, 1'b0, HSQ_EV_DECEL, 1'b0);
        r = hsq_mk(HSQ_SPD_ZERO, 1'b0, HSQ_EV_DECEL, 1'b1);
        zrev = (m != HSQ_METHOD_13);
        if (m == HSQ_METHOD_17) begin
            if (v == HSQ_VAR_ON) begin
                r = hsq_mk(HSQ_SPD_LOW, 1'b0, HSQ_EV_RLIM_FALL, 1'b1);
            end else begin
                case (s)
                    3'h0: r = hsq_mk(HSQ_SPD_HIGH, 1'b1, HSQ_EV_RLIM_RISE, 1'b0);
                    3'h1: r = dc;
                    default: r = hsq_mk(HSQ_SPD_LOW, 1'b0, HSQ_EV_RLIM_FALL, 1'b1);
                endcase
            end
        end else if (m == HSQ_METHOD_12 && v == HSQ_VAR_ON) begin
            case (s)
                3'h0: r = hsq_mk(HSQ_SPD_LOW, 1'b0, HSQ_EV_HOME_FALL, 1'b0);
                3'h1: r = hsq_mk(HSQ_SPD_LOW, 1'b1, HSQ_EV_HOME_RISE, 1'b0);
                default: r = hsq_mk(HSQ_SPD_LOW, 1'b1, HSQ_EV_INDEX, 1'b1);
            endcase
        end else if (m == HSQ_METHOD_12 && v == HSQ_VAR_OFF) begin
            case (s)
                3'h0: r = hsq_mk(HSQ_SPD_HIGH, 1'b1, HSQ_EV_HOME_RISE, 1'b0);
                3'h1: r = dc;
                3'h2: r = hsq_mk(HSQ_SPD_LOW, 1'b0, HSQ_EV_HOME_FALL, 1'b0);
                3'h3: r = hsq_mk(HSQ_SPD_LOW, 1'b1, HSQ_EV_HOME_RISE, 1'b0);
                default: r = hsq_mk(HSQ_SPD_LOW, 1'b1, HSQ_EV_INDEX, 1'b1);
            endcase
        end else if (m == HSQ_METHOD_12) begin
            case (s)
                3'h0: r = hsq_mk(HSQ_SPD_HIGH, 1'b0, HSQ_EV_HOME_FALL, 1'b0);
                3'h1: r = dc;
                3'h2: r = hsq_mk(HSQ_SPD_LOW, 1'b1, HSQ_EV_HOME_RISE, 1'b0);
                default: r = hsq_mk(HSQ_SPD_LOW, 1'b1, HSQ_EV_INDEX, 1'b1);
            endcase
        end else if (v != HSQ_VAR_LIMIT) begin
            // Methods 13 and 14 run the same sequence from either home level
            case (s)
                3'h0: r = hsq_mk(HSQ_SPD_HIGH, 1'b1, HSQ_EV_HOME_FALL, 1'b0);
                3'h1: r = dc;
                3'h2: r = hsq_mk(HSQ_SPD_LOW, 1'b0, HSQ_EV_HOME_RISE, 1'b0);
                3'h3: r = zrev ? hsq_mk(HSQ_SPD_LOW, 1'b1, HSQ_EV_HOME_FALL, 1'b0)
                               : hsq_mk(HSQ_SPD_LOW, 1'b0, HSQ_EV_INDEX, 1'b1);
                default: r = hsq_mk(HSQ_SPD_LOW, 1'b1, HSQ_EV_INDEX, 1'b1);
            endcase
        end else begin
            case (s)
                3'h0: r = hsq_mk(HSQ_SPD_HIGH, 1'b0, HSQ_EV_HOME_RISE, 1'b0);
                3'h1: r = dc;
                3'h2: r = hsq_mk(HSQ_SPD_LOW, 1'b1, HSQ_EV_HOME_FALL, 1'b0);
                3'h3: r = zrev ? hsq_mk(HSQ_SPD_LOW, 1'b1, HSQ_EV_INDEX, 1'b1)
                               : hsq_mk(HSQ_SPD_LOW, 1'b0, HSQ_EV_HOME_RISE, 1'b0);
                default: r = hsq_mk(HSQ_SPD_LOW, 1'b0, HSQ_EV_INDEX, 1'b1);
            endcase
        end
        return r;
    endfunction : hsq_step

endpackage : hsq_pkg

// File: verilog/hsq_sync.sv
// Two-flop synchroniser with edge detection for pin inputs
module hsq_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;
    logic [WIDTH-1:0] next_prev;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb begin
        next_meta = pin;
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    // ------------------------------------------------------------
    // Level and edges
    // ------------------------------------------------------------
    assign level = sync;
    assign rise = sync & ~prev;
    assign fall = ~sync & prev;

endmodule : hsq_sync

// File: verif/hsq_axis_model.sv
// Axis model giving home switch, reverse limit and index from position
module hsq_axis_model
    import hsq_pkg::*;
#(
    parameter int HOME_LO = 200,
    parameter int HOME_HI = 260,
    parameter int PITCH = 16
) (
    input wire logic clock,
    input wire logic load,
    input wire logic signed [31:0] load_pos,
    input wire logic [1:0] speed_cmd,
    input wire logic dir_rev,
    output logic home_sw,
    output logic rev_limit,
    output logic index_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int pos = 0;
    int step;
    always @(posedge clock) begin
        step = (speed_cmd == HSQ_SPD_HIGH) ? 4 : ((speed_cmd == HSQ_SPD_LOW) ? 1 : 0);
        if (load) begin
            pos <= load_pos;
        end else begin
            pos <= dir_rev ? pos - step : pos + step;
        end
    end
    assign home_sw = (pos >= HOME_LO) && (pos <= HOME_HI);
    assign rev_limit = (pos <= 0);
    assign index_pulse = (pos % PITCH) == 0;
endmodule : hsq_axis_model

// File: verif/hsq_homing_properties.sv
// Port checks of the homing sequencer
module hsq_homing_properties
    import hsq_pkg::*;
#(
    parameter int DECEL_CYCLES = 4
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic start,
    input wire logic [7:0] method,
    input wire logic home_sw,
    input wire logic rev_limit,
    input wire logic index_pulse,
    input wire logic [1:0] speed_cmd,
    input wire logic dir_rev,
    input wire logic busy,
    input wire logic done,
    input wire logic fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic go;
    logic [31:0] zrun;
    logic [31:0] next_zrun;
    default clocking dflt @(posedge clock);
    endclocking
    default disable iff (!rstn);
    assign go = start && !busy;
    always_comb begin
        next_zrun = (busy && speed_cmd == HSQ_SPD_ZERO) ? zrun + 32'h1 : HSQ_CNT_RST;
    end
    always_ff @(posedge clock) begin
        zrun <= rstn ? next_zrun : HSQ_CNT_RST;
    end
    chk_reserved_fault: assert property (
        go && (method == HSQ_METHOD_15 || method == HSQ_METHOD_16)
        |=> fault && !busy && speed_cmd == HSQ_SPD_ZERO) else $error("reserved code moved");
    chk_m12_off: assert property (
        go && method == HSQ_METHOD_12 && !home_sw |=> busy && speed_cmd == HSQ_SPD_HIGH && dir_rev)
        else $error("m12 off first phase");
    chk_m12_on: assert property (
        go && method == HSQ_METHOD_12 && home_sw |=> busy && speed_cmd == HSQ_SPD_LOW && !dir_rev)
        else $error("m12 on first phase");
    chk_m13_14_first: assert property (
        go && (method == HSQ_METHOD_13 || method == HSQ_METHOD_14)
        |=> busy && speed_cmd == HSQ_SPD_HIGH && dir_rev) else $error("m13/14 first phase");
    chk_m17_off: assert property (
        go && method == HSQ_METHOD_17 && !rev_limit |=> speed_cmd == HSQ_SPD_HIGH && dir_rev)
        else $error("m17 off first phase");
    chk_m17_on: assert property (
        go && method == HSQ_METHOD_17 && rev_limit |=> speed_cmd == HSQ_SPD_LOW && !dir_rev)
        else $error("m17 on first phase");
    chk_decel_len: assert property (
        busy && speed_cmd != HSQ_SPD_ZERO && $past(busy) && $past(speed_cmd) == HSQ_SPD_ZERO
        |-> zrun >= DECEL_CYCLES && zrun <= DECEL_CYCLES + 1) else $error("decel length");
    chk_done_idle: assert property (
        done |-> !busy && !fault && speed_cmd == HSQ_SPD_ZERO) else $error("done while moving");
    chk_done_hold: assert property (
        done && !start |=> done && speed_cmd == HSQ_SPD_ZERO) else $error("done not held");
    chk_limit_turn: assert property (
        busy && speed_cmd == HSQ_SPD_HIGH && dir_rev && rev_limit
        |-> ##[1:5] (!dir_rev || speed_cmd == HSQ_SPD_ZERO)) else $error("limit not obeyed");
    chk_done_event: assert property (
        $rose(done) |-> $past(index_pulse, 3) || ($past(rev_limit, 4) && !$past(rev_limit, 3)))
        else $error("done without final event");
endmodule : hsq_homing_properties
bind hsq_homing hsq_homing_properties #(.DECEL_CYCLES(DECEL_CYCLES)) chk_u (
    .clock(clock), .rstn(rstn), .start(start), .method(method), .home_sw(home_sw),
    .rev_limit(rev_limit), .index_pulse(index_pulse), .speed_cmd(speed_cmd),
    .dir_rev(dir_rev), .busy(busy), .done(done), .fault(fault));

// File: verif/test_homing_sequencer_methods_12_to_17.sv
// Testbench of the homing sequencer against the axis model
module test_homing_sequencer_methods_12_to_17;
    timeunit 1ns;
    timeprecision 1ps;
    import hsq_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic [7:0] method = 8'h00;
    logic load = 1'b0;
    logic signed [31:0] load_pos = 32'h0;
    logic home_sw, rev_limit, index_pulse, dir_rev, busy, done, fault;
    logic [1:0] speed_cmd;
    logic [4:0] exp_q[$];
    logic [4:0] seen = 5'h00;
    logic [4:0] key;
    int err_total = 0;
    int check_count = 0;
    int seed = 32'h37561A16;
    always #4 clock = ~clock;
    hsq_homing #(.DECEL_CYCLES(4)) dut_u (.clock(clock), .rstn(rstn), .start(start),
        .method(method), .home_sw(home_sw), .rev_limit(rev_limit), .index_pulse(index_pulse),
        .speed_cmd(speed_cmd), .dir_rev(dir_rev), .busy(busy), .done(done), .fault(fault));
    hsq_axis_model axis_u (.clock(clock), .load(load), .load_pos(load_pos),
        .speed_cmd(speed_cmd), .dir_rev(dir_rev), .home_sw(home_sw), .rev_limit(rev_limit),
        .index_pulse(index_pulse));
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    task automatic compare_phase(input logic [4:0] got, input logic [4:0] want);
        check_count++;
        if (got !== want) begin
            err_total++;
            $display("unexpected at %0t: phase %h wanted %h", $time, got, want);
        end
    endtask : compare_phase
    task automatic compare_flag(input logic got, input logic want);
        check_count++;
        if (got !== want) begin
            err_total++;
            $display("unexpected at %0t: busy %b wanted %b", $time, got, want);
        end
    endtask : compare_flag
    // ----
    // Watcher: phase code {done, fault, speed, reverse}
    // ----
    always @(negedge clock) begin
        key = {done, fault, speed_cmd, dir_rev & (speed_cmd != HSQ_SPD_ZERO)};
        if (rstn && key !== seen) begin
            seen = key;
            if (exp_q.size() == 0) begin
                compare_phase(key, 5'h1F);
            end else begin
                compare_phase(key, exp_q.pop_front());
            end
        end
    end
    // Phases: 05 fast rev, 04 fast fwd, 03 slow rev, 02 slow fwd, 00 stop, 10 done, 08 fault
    task automatic run(input logic [7:0] m, input int base, input logic [29:0] ph, input int n,
                       input logic dbl);
        int i;
        @(posedge clock);
        #1;
        load = 1'b1;
        load_pos = base + ($random(seed) & 15);
        @(posedge clock);
        #1;
        load = 1'b0;
        for (i = n - 1; i >= 0; i--) exp_q.push_back(ph[i*5 +: 5]);
        repeat (4) @(posedge clock);
        #1;
        start = 1'b1;
        method = m;
        @(posedge clock);
        #1;
        compare_flag(busy, m != HSQ_METHOD_15 && m != HSQ_METHOD_16);
        start = dbl;
        method = HSQ_METHOD_15;
        @(posedge clock);
        #1;
        start = 1'b0;
        for (i = 0; i < 3000 && done !== 1'b1 && fault !== 1'b1; i++) @(posedge clock);
        repeat (12) @(posedge clock);
        compare_flag(busy, 1'b0);
        check_count++;
        if (i >= 3000 || exp_q.size() != 0) begin
            err_total++;
            $display("unexpected at %0t: %0d phases missing", $time, exp_q.size());
            exp_q.delete();
        end
        $display("test method %0d ended", m);
    endtask : run
    initial begin
        repeat (2) @(posedge clock);
        #1;
        rstn = 1'b1;
        run(HSQ_METHOD_12, 300, 30'({5'h05, 5'h00, 5'h02, 5'h03, 5'h10}), 5, 1'b0);
        run(HSQ_METHOD_12, 230, 30'({5'h02, 5'h03, 5'h10}), 3, 1'b0);
        run(HSQ_METHOD_12, 100, 30'({5'h05, 5'h04, 5'h00, 5'h03, 5'h10}), 5, 1'b0);
        run(HSQ_METHOD_13, 300, 30'({5'h05, 5'h00, 5'h02, 5'h10}), 4, 1'b0);
        run(HSQ_METHOD_13, 230, 30'({5'h05, 5'h00, 5'h02, 5'h10}), 4, 1'b0);
        run(HSQ_METHOD_13, 100, 30'({5'h05, 5'h04, 5'h00, 5'h03, 5'h02, 5'h10}), 6, 1'b1);
        run(HSQ_METHOD_14, 300, 30'({5'h05, 5'h00, 5'h02, 5'h03, 5'h10}), 5, 1'b0);
        run(HSQ_METHOD_14, 230, 30'({5'h05, 5'h00, 5'h02, 5'h03, 5'h10}), 5, 1'b0);
        run(HSQ_METHOD_14, 100, 30'({5'h05, 5'h04, 5'h00, 5'h03, 5'h10}), 5, 1'b0);
        run(HSQ_METHOD_17, 100, 30'({5'h05, 5'h00, 5'h02, 5'h10}), 4, 1'b0);
        run(HSQ_METHOD_17, -20, 30'({5'h02, 5'h10}), 2, 1'b0);
        run(HSQ_METHOD_15, 300, 30'(5'h08), 1, 1'b0);
        run(HSQ_METHOD_17, -20, 30'({5'h02, 5'h10}), 2, 1'b0);
        run(HSQ_METHOD_16, 300, 30'(5'h08), 1, 1'b0);
        summarize();
    end
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        $display("unexpected at %0t: run too long", $time);
        summarize();
    end
endmodule : test_homing_sequencer_methods_12_to_17
